// ---- hdl/gsl_pkg.sv ----
// Package for the six-pad port and the network status lamp: map, fields, modes, timing
// Assumes one 25 MHz clock and AXI4-Lite with 32-bit data on the register side
package gsl_pkg;
  localparam int NUM_PADS = 6;
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 32;
  localparam int CNT_W    = 27;
  localparam int CLK_HZ   = 25_000_000;

  // Register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] PAD_CFG_BASE  = 6'h00;
  localparam logic [ADDR_W-1:0] PAD_IN_OFF    = 6'h18;
  localparam logic [ADDR_W-1:0] LAMP_MODE_OFF = 6'h1C;
  localparam int                NUM_WORDS     = 8;

  // Pad configuration fields and reset value
  localparam int         CFG_DIR_BIT  = 0;
  localparam int         CFG_ALT_BIT  = 1;
  localparam int         CFG_PULL_BIT = 2;
  localparam int         CFG_OUT_BIT  = 3;
  localparam int         CFG_W        = 4;
  localparam logic [3:0] CFG_RST      = 4'h0;

  typedef struct packed {
    logic out_val;
    logic pull_up;
    logic alt;
    logic dir;
  } gsl_pad_cfg_t;

  typedef enum logic [1:0] {
    LAMP_OFF     = 2'h0,
    LAMP_OFFLINE = 2'h1,
    LAMP_ONLINE  = 2'h2,
    LAMP_SENDING = 2'h3
  } gsl_lamp_mode_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } gsl_wr_state_t;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Blink rates in millihertz, duty in percent
  localparam longint OFFLINE_FREQ_MHZ = 1000;
  localparam longint ONLINE_FREQ_MHZ  = 300;
  localparam longint SENDING_FREQ_MHZ = 10000;
  localparam longint OFFLINE_DUTY_PCT = 50;
  localparam longint ONLINE_DUTY_PCT  = 10;
  localparam longint SENDING_DUTY_PCT = 50;

  // Periods round down, on-times follow the rounded period
  localparam longint OFFLINE_PERIOD_CYC = longint'(CLK_HZ) * 1000 / OFFLINE_FREQ_MHZ;
  localparam longint ONLINE_PERIOD_CYC  = longint'(CLK_HZ) * 1000 / ONLINE_FREQ_MHZ;
  localparam longint SENDING_PERIOD_CYC = longint'(CLK_HZ) * 1000 / SENDING_FREQ_MHZ;
  localparam longint OFFLINE_ON_CYC     = OFFLINE_PERIOD_CYC * OFFLINE_DUTY_PCT / 100;
  localparam longint ONLINE_ON_CYC      = ONLINE_PERIOD_CYC * ONLINE_DUTY_PCT / 100;
  localparam longint SENDING_ON_CYC     = SENDING_PERIOD_CYC * SENDING_DUTY_PCT / 100;
endpackage : gsl_pkg

// ---- hdl/gsl_pad_cell.sv ----
// One pad: picks the general-purpose or alternate driver and registers the pad output and enable; pulls pass straight through
// Assumes the configuration comes from registers in the top module
module gsl_pad_cell (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  gsl_pkg::gsl_pad_cfg_t cfg_i,
  input  wire logic          alt_oe_i,
  input  wire logic          alt_out_i,
  output logic               pad_o,
  output logic               pad_oe_o,
  output logic               pull_up_o,
  output logic               pull_down_o
);
  logic out_reg;
  logic out_next;
  logic oe_reg;
  logic oe_next;

  // Alternate function owns the pad; otherwise push-pull from the config
  always_comb begin
    if (cfg_i.alt) begin
      oe_next  = alt_oe_i;
      out_next = alt_out_i;
    end else begin
      oe_next  = cfg_i.dir;
      out_next = cfg_i.out_val;
    end
  end

  // Driver off in reset so the pad comes up as an input
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      oe_reg  <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      oe_reg  <= oe_next;
      out_reg <= out_next;
    end
  end

  // Pull always selects one side; never both, never floating
  assign pull_up_o   = cfg_i.pull_up;
  assign pull_down_o = ~cfg_i.pull_up;
  assign pad_o       = out_reg;
  assign pad_oe_o    = oe_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_alt_follow;
    cfg_i.alt |=> (pad_oe_o == $past(alt_oe_i)) && (pad_o == $past(alt_out_i));
  endproperty
  a_alt_follow: assert property (p_alt_follow) else $error("alt pad not driven by function");

  property p_push_pull;
    (!cfg_i.alt && cfg_i.dir) |=> pad_oe_o && (pad_o == $past(cfg_i.out_val));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("output pad not driven both levels");

  c_alt_drive: cover property (cfg_i.alt && alt_oe_i ##1 pad_oe_o);
endmodule : gsl_pad_cell

// ---- hdl/gsl_lamp_blink.sv ----
// Blink generator: free counter over one period, lamp on for the first on-count cycles
// Assumes period and on-count are steady while enabled; restart realigns the phase
module gsl_lamp_blink (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      restart_i,
  input  wire logic                      enable_i,
  input  wire logic [gsl_pkg::CNT_W-1:0] period_i,
  input  wire logic [gsl_pkg::CNT_W-1:0] on_i,
  output logic                           lamp_on_o
);
  logic [gsl_pkg::CNT_W-1:0] cnt_reg;
  logic [gsl_pkg::CNT_W-1:0] cnt_next;
  logic                      lamp_reg;
  logic                      lamp_next;
  logic                      wrap;

  assign wrap = (cnt_reg >= period_i - gsl_pkg::CNT_W'(1));

  // Counter restarts on mode change so a new pattern starts lit
  always_comb begin
    if (restart_i || !enable_i) begin
      cnt_next = '0;
    end else if (wrap) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + gsl_pkg::CNT_W'(1);
    end
    lamp_next = enable_i && !restart_i && (cnt_reg < on_i);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg  <= '0;
      lamp_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      lamp_reg <= lamp_next;
    end
  end

  assign lamp_on_o = lamp_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Lamp flop lags the counter, so the wrap edge still shows the dark tail of the period
  property p_blink_wrap;
    (enable_i && !restart_i && cnt_reg == period_i - gsl_pkg::CNT_W'(1)) |=> (cnt_reg == '0) && !lamp_on_o;
  endproperty
  a_blink_wrap: assert property (p_blink_wrap) else $error("blink period not kept");

  c_blink_wrap: cover property (enable_i && wrap);
endmodule : gsl_lamp_blink

// ---- hdl/gsl_top.sv ----
// Six-pad configurable port and network status lamp behind an AXI4-Lite slave
// Assumes pad inputs synchronous to clk_i and alternate function logic on the same clock
module gsl_top #(
  parameter int OFFLINE_PERIOD_CYC = int'(gsl_pkg::OFFLINE_PERIOD_CYC),
  parameter int OFFLINE_ON_CYC     = int'(gsl_pkg::OFFLINE_ON_CYC),
  parameter int ONLINE_PERIOD_CYC  = int'(gsl_pkg::ONLINE_PERIOD_CYC),
  parameter int ONLINE_ON_CYC      = int'(gsl_pkg::ONLINE_ON_CYC),
  parameter int SENDING_PERIOD_CYC = int'(gsl_pkg::SENDING_PERIOD_CYC),
  parameter int SENDING_ON_CYC     = int'(gsl_pkg::SENDING_ON_CYC)
) (
  input  wire logic                          clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic [gsl_pkg::ADDR_W-1:0]    s_axi_awaddr_i,
  input  wire logic                          s_axi_awvalid_i,
  output logic                               s_axi_awready_o,
  input  wire logic [gsl_pkg::DATA_W-1:0]    s_axi_wdata_i,
  input  wire logic [3:0]                    s_axi_wstrb_i,
  input  wire logic                          s_axi_wvalid_i,
  output logic                               s_axi_wready_o,
  output logic [1:0]                         s_axi_bresp_o,
  output logic                               s_axi_bvalid_o,
  input  wire logic                          s_axi_bready_i,
  input  wire logic [gsl_pkg::ADDR_W-1:0]    s_axi_araddr_i,
  input  wire logic                          s_axi_arvalid_i,
  output logic                               s_axi_arready_o,
  output logic [gsl_pkg::DATA_W-1:0]         s_axi_rdata_o,
  output logic [1:0]                         s_axi_rresp_o,
  output logic                               s_axi_rvalid_o,
  input  wire logic                          s_axi_rready_i,
  input  wire logic [gsl_pkg::NUM_PADS-1:0]  pad_i,
  output logic [gsl_pkg::NUM_PADS-1:0]       pad_o,
  output logic [gsl_pkg::NUM_PADS-1:0]       pad_oe_o,
  output logic [gsl_pkg::NUM_PADS-1:0]       pad_pull_up_o,
  output logic [gsl_pkg::NUM_PADS-1:0]       pad_pull_down_o,
  input  wire logic [gsl_pkg::NUM_PADS-1:0]  alt_oe_i,
  input  wire logic [gsl_pkg::NUM_PADS-1:0]  alt_out_i,
  output logic [gsl_pkg::NUM_PADS-1:0]       alt_in_o,
  output logic                               network_status_lamp_pin_o
);
  localparam int N   = gsl_pkg::NUM_PADS;
  localparam int CW  = gsl_pkg::CNT_W;

  gsl_pkg::gsl_wr_state_t    wr_state_reg;
  gsl_pkg::gsl_wr_state_t    wr_state_next;
  logic                      aw_got_reg;
  logic                      aw_got_next;
  logic                      w_got_reg;
  logic                      w_got_next;
  logic [gsl_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [gsl_pkg::ADDR_W-1:0] aw_addr_next;
  logic [gsl_pkg::DATA_W-1:0] w_data_reg;
  logic [gsl_pkg::DATA_W-1:0] w_data_next;
  logic [3:0]                w_strb_reg;
  logic [3:0]                w_strb_next;
  logic [1:0]                bresp_reg;
  logic [1:0]                bresp_next;
  logic                      aw_fire;
  logic                      w_fire;
  logic                      do_write;
  logic [gsl_pkg::ADDR_W-1:0] wr_addr;
  logic [gsl_pkg::DATA_W-1:0] wr_data;
  logic [3:0]                wr_strb;
  logic [3:0]                wr_idx;
  logic                      rvalid_reg;
  logic                      rvalid_next;
  logic [gsl_pkg::DATA_W-1:0] rdata_reg;
  logic [gsl_pkg::DATA_W-1:0] rdata_next;
  logic [1:0]                rresp_reg;
  logic [1:0]                rresp_next;
  logic                      ar_fire;
  logic [3:0]                rd_idx;
  gsl_pkg::gsl_pad_cfg_t     cfg_reg  [N];
  gsl_pkg::gsl_pad_cfg_t     cfg_next [N];
  gsl_pkg::gsl_lamp_mode_t   lamp_mode_reg;
  gsl_pkg::gsl_lamp_mode_t   lamp_mode_next;
  logic [CW-1:0]             period_sel;
  logic [CW-1:0]             on_sel;
  logic                      lamp_on;
  logic                      pin_reg;
  logic                      pin_next;
  logic [N-1:0]              alt_in_reg;
  logic [N-1:0]              alt_in_next;

  // Write channel: address and data taken in either order, response after both
  assign s_axi_awready_o = (wr_state_reg == gsl_pkg::WR_IDLE) && !aw_got_reg;
  assign s_axi_wready_o  = (wr_state_reg == gsl_pkg::WR_IDLE) && !w_got_reg;
  assign aw_fire  = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire   = s_axi_wvalid_i && s_axi_wready_o;
  assign do_write = (wr_state_reg == gsl_pkg::WR_IDLE) && (aw_got_reg || aw_fire) && (w_got_reg || w_fire);
  assign wr_addr  = aw_got_reg ? aw_addr_reg : s_axi_awaddr_i;
  assign wr_data  = w_got_reg ? w_data_reg : s_axi_wdata_i;
  assign wr_strb  = w_got_reg ? w_strb_reg : s_axi_wstrb_i;
  assign wr_idx   = wr_addr[5:2];
  assign s_axi_bvalid_o = (wr_state_reg == gsl_pkg::WR_RESP);
  assign s_axi_bresp_o  = bresp_reg;

  always_comb begin
    wr_state_next = wr_state_reg;
    aw_got_next   = aw_got_reg || aw_fire;
    w_got_next    = w_got_reg || w_fire;
    aw_addr_next  = aw_fire ? s_axi_awaddr_i : aw_addr_reg;
    w_data_next   = w_fire ? s_axi_wdata_i : w_data_reg;
    w_strb_next   = w_fire ? s_axi_wstrb_i : w_strb_reg;
    bresp_next    = bresp_reg;
    unique case (wr_state_reg)
      gsl_pkg::WR_IDLE: begin
        if (do_write) begin
          wr_state_next = gsl_pkg::WR_RESP;
          aw_got_next   = 1'b0;
          w_got_next    = 1'b0;
          bresp_next    = (32'(wr_idx) < gsl_pkg::NUM_WORDS) ? gsl_pkg::RESP_OKAY : gsl_pkg::RESP_SLVERR;
        end
      end
      gsl_pkg::WR_RESP: begin
        if (s_axi_bready_i) begin
          wr_state_next = gsl_pkg::WR_IDLE;
        end
      end
      default: begin
        wr_state_next = gsl_pkg::WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_state_reg <= gsl_pkg::WR_IDLE;
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      aw_addr_reg  <= '0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      bresp_reg    <= gsl_pkg::RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_got_reg   <= aw_got_next;
      w_got_reg    <= w_got_next;
      aw_addr_reg  <= aw_addr_next;
      w_data_reg   <= w_data_next;
      w_strb_reg   <= w_strb_next;
      bresp_reg    <= bresp_next;
    end
  end

  // Per-pad words so one write never touches another pad's settings
  always_comb begin
    gsl_pkg::gsl_pad_cfg_t nw;
    nw = '0;
    lamp_mode_next = lamp_mode_reg;
    for (int i = 0; i < N; i++) begin
      cfg_next[i] = cfg_reg[i];
      if (do_write && wr_strb[0] && (wr_idx == gsl_pkg::PAD_CFG_BASE[5:2] + 4'(i))) begin
        nw = gsl_pkg::gsl_pad_cfg_t'(wr_data[gsl_pkg::CFG_W-1:0]);
        if (!nw.dir) begin
          nw.out_val = cfg_reg[i].out_val;
        end
        cfg_next[i] = nw;
      end
    end
    if (do_write && wr_strb[0] && (wr_idx == gsl_pkg::LAMP_MODE_OFF[5:2])) begin
      lamp_mode_next = gsl_pkg::gsl_lamp_mode_t'(wr_data[1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < N; i++) begin
        cfg_reg[i] <= gsl_pkg::CFG_RST;
      end
      lamp_mode_reg <= gsl_pkg::LAMP_OFF;
    end else begin
      for (int i = 0; i < N; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      lamp_mode_reg <= lamp_mode_next;
    end
  end

  // Read channel: pad levels captured at the edge the address is taken
  assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_idx  = s_axi_araddr_i[5:2];
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  always_comb begin
    rvalid_next = rvalid_reg && !s_axi_rready_i;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (ar_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = gsl_pkg::RESP_OKAY;
      rdata_next  = '0;
      if (32'(rd_idx) < N) begin
        rdata_next = 32'(cfg_reg[3'(rd_idx)]);
      end else if (rd_idx == gsl_pkg::PAD_IN_OFF[5:2]) begin
        rdata_next = 32'(pad_i);
      end else if (rd_idx == gsl_pkg::LAMP_MODE_OFF[5:2]) begin
        rdata_next = 32'(lamp_mode_reg);
      end else begin
        rresp_next = gsl_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= gsl_pkg::RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  // Pad cells, one per pad
  for (genvar g = 0; g < N; g++) begin : g_pad
    gsl_pad_cell u_pad (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .cfg_i       (cfg_reg[g]),
      .alt_oe_i    (alt_oe_i[g]),
      .alt_out_i   (alt_out_i[g]),
      .pad_o       (pad_o[g]),
      .pad_oe_o    (pad_oe_o[g]),
      .pull_up_o   (pad_pull_up_o[g]),
      .pull_down_o (pad_pull_down_o[g])
    );
  end

  // Lamp pattern select; counts are parameters so a bench can shrink them
  always_comb begin
    unique case (lamp_mode_reg)
      gsl_pkg::LAMP_OFFLINE: begin
        period_sel = CW'(OFFLINE_PERIOD_CYC);
        on_sel     = CW'(OFFLINE_ON_CYC);
      end
      gsl_pkg::LAMP_ONLINE: begin
        period_sel = CW'(ONLINE_PERIOD_CYC);
        on_sel     = CW'(ONLINE_ON_CYC);
      end
      gsl_pkg::LAMP_SENDING: begin
        period_sel = CW'(SENDING_PERIOD_CYC);
        on_sel     = CW'(SENDING_ON_CYC);
      end
      gsl_pkg::LAMP_OFF: begin
        period_sel = '0;
        on_sel     = '0;
      end
    endcase
  end

  gsl_lamp_blink u_blink (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (lamp_mode_next != lamp_mode_reg),
    .enable_i  (lamp_mode_reg != gsl_pkg::LAMP_OFF),
    .period_i  (period_sel),
    .on_i      (on_sel),
    .lamp_on_o (lamp_on)
  );

  // External transistor inverts, so the pin idles high with the lamp dark
  always_comb begin
    pin_next    = ~lamp_on;
    alt_in_next = pad_i;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_reg    <= 1'b1;
      alt_in_reg <= '0;
    end else begin
      pin_reg    <= pin_next;
      alt_in_reg <= alt_in_next;
    end
  end

  assign network_status_lamp_pin_o = pin_reg;
  assign alt_in_o                  = alt_in_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_in_read;
    (ar_fire && rd_idx == gsl_pkg::PAD_IN_OFF[5:2]) |=> s_axi_rvalid_o && (s_axi_rdata_o[N-1:0] == $past(pad_i));
  endproperty
  a_in_read: assert property (p_in_read) else $error("input read not the sampled level");

  property p_in_write;
    (do_write && wr_strb[0] && wr_idx == 4'h0 && !wr_data[0]) |=> cfg_reg[0].out_val == $past(cfg_reg[0].out_val);
  endproperty
  a_in_write: assert property (p_in_write) else $error("write changed an input pad value");

  property p_out_query;
    (ar_fire && rd_idx == 4'h1) |=> s_axi_rdata_o[gsl_pkg::CFG_W-1:0] == $past(cfg_reg[1]);
  endproperty
  a_out_query: assert property (p_out_query) else $error("output query mismatch");

  property p_reset_input;
    $fell(sys_rst_i) |-> (pad_oe_o == '0) && (cfg_reg[0] == gsl_pkg::CFG_RST) && (cfg_reg[5] == gsl_pkg::CFG_RST);
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pad not input after reset");

  property p_pull;
    (pad_pull_up_o == ~pad_pull_down_o) && (pad_pull_up_o[2] == cfg_reg[2].pull_up);
  endproperty
  a_pull: assert property (p_pull) else $error("pull selection wrong");

  property p_lamp_inv;
    ##1 (network_status_lamp_pin_o == !$past(lamp_on));
  endproperty
  a_lamp_inv: assert property (p_lamp_inv) else $error("lamp pin not inverted");

  property p_lamp_off;
    (lamp_mode_reg == gsl_pkg::LAMP_OFF)[*3] |-> network_status_lamp_pin_o;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp lit while off");

  property p_pad_isolation;
    (do_write && wr_idx == 4'h2) |=> cfg_reg[3] == $past(cfg_reg[3]);
  endproperty
  a_pad_isolation: assert property (p_pad_isolation) else $error("write disturbed another pad");

  property p_bresp;
    do_write |=> s_axi_bvalid_o;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response missing");

  c_write:   cover property (do_write ##1 s_axi_bvalid_o && s_axi_bready_i);
  c_in_read: cover property (ar_fire && rd_idx == gsl_pkg::PAD_IN_OFF[5:2]);
  c_sending: cover property (lamp_mode_reg == gsl_pkg::LAMP_SENDING && !network_status_lamp_pin_o);
endmodule : gsl_top

// ---- tb/gsl_pad_partner.sv ----
// Far side of the six pads: external 1.8 V devices, pull resistors, lamp transistor
// Assumes the bench picks which pads an external device drives and at what level
module gsl_pad_partner (
  input  wire logic [5:0] drv_i,
  input  wire logic [5:0] oe_i,
  input  wire logic [5:0] pu_i,
  input  wire logic [5:0] ext_en_i,
  input  wire logic [5:0] ext_val_i,
  input  wire logic       lamp_pin_i,
  output logic      [5:0] level_o,
  output logic            lamp_lit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wire level: device driver first, then external driver, else the pull resistor
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (oe_i[i]) level_o[i] = drv_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else level_o[i] = pu_i[i];
    end
  end
  // Inverting transistor lights the lamp while the pin is low
  assign lamp_lit_o = ~lamp_pin_i;
endmodule : gsl_pad_partner

// ---- tb/gsl_top_tb.sv ----
// Self-checking bench for the six-pad port and status lamp, AXI4-Lite master in tasks
// Assumes short lamp periods via parameters; pads see the partner's resolved wire level
module gsl_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, awv, wv, bv, br, arv, rv, rr, awr, wr, arr, pin, lit;
  logic [5:0] awa, ara, pin_lv, p_o, p_oe, pu, pd, aoe, aout, xen, xval, ain;
  logic [31:0] wd, rd;
  logic [1:0]  br_c, rr_c;
  logic [3:0]  ws;
  int miscompares, n_compared;
  gsl_top #(.OFFLINE_PERIOD_CYC(20), .OFFLINE_ON_CYC(10), .ONLINE_PERIOD_CYC(40), .ONLINE_ON_CYC(4),
    .SENDING_PERIOD_CYC(10), .SENDING_ON_CYC(5)) uut (.clk_i(clk), .sys_rst_i(rst),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br_c),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr_c), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rr), .pad_i(pin_lv), .pad_o(p_o), .pad_oe_o(p_oe), .pad_pull_up_o(pu),
    .pad_pull_down_o(pd), .alt_oe_i(aoe), .alt_out_i(aout), .alt_in_o(ain),
    .network_status_lamp_pin_o(pin));
  gsl_pad_partner far (.drv_i(p_o), .oe_i(p_oe), .pu_i(pu), .ext_en_i(xen), .ext_val_i(xval),
    .lamp_pin_i(pin), .level_o(pin_lv), .lamp_lit_o(lit));
  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // A used-up wait bound counts as a mismatch and ends the run
  task automatic tmo(input int n);
    if (n >= 100) begin
      miscompares++;
      $display("[ERR] %0t handshake wait ran out", $time);
      results();
    end
  endtask : tmo
  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit ta, tw;
    n = 0; ta = 0; tw = 0;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk); n++;
      if (!ta && awr) begin ta = 1; awv <= 1'b0; end
      if (!tw && wr) begin tw = 1; wv <= 1'b0; end
    end while (!(ta && tw) && n < 100);
    do begin @(posedge clk); n++; end while (!bv && n < 100);
    tmo(n);
    r = br_c;
    br <= 1'b0;
  endtask : axw
  task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin @(posedge clk); n++; end while (!arr && n < 100);
    arv <= 1'b0;
    do begin @(posedge clk); n++; end while (!rv && n < 100);
    tmo(n);
    d = rd; r = rr_c;
    rr <= 1'b0;
  endtask : axr
  // Pads follow a config write two edges later
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic t_reset();
    chk(p_oe, 6'h00);
    chk(pd, 6'h3F);
    chk(pin, 1'b1);
  endtask : t_reset
  task automatic t_input();
    logic [31:0] d;
    logic [1:0] r;
    xen <= 6'h3F; xval <= 6'h2D;
    axw(6'h00, 32'h0000_0008, r);
    settle();
    axr(gsl_pkg::PAD_IN_OFF, d, r);
    chk(d, 32'h0000_002D);
    axr(6'h00, d, r);
    chk(d, 32'h0000_0000);
    chk(p_oe, 6'h00);
    chk(ain, 6'h2D);
  endtask : t_input
  task automatic t_output();
    logic [31:0] d;
    logic [1:0] r;
    xen <= 6'h3B;
    axw(6'h08, 32'h0000_0009, r);
    chk(r, gsl_pkg::RESP_OKAY);
    settle();
    chk({p_oe, pin_lv[2]}, {6'h04, 1'b1});
    axr(6'h08, d, r);
    chk(d, 32'h0000_0009);
    axw(6'h08, 32'h0000_0001, r);
    settle();
    chk({p_o[2], pin_lv[2], p_oe}, {2'b00, 6'h04});
    xen <= 6'h39;
    axw(6'h04, 32'h0000_0004, r);
    settle();
    chk({pu, pd, pin_lv[1]}, {6'h02, 6'h3D, 1'b1});
    chk(p_oe, 6'h04);
    // Write with the low strobe off must leave the pad word alone
    ws <= 4'h0;
    axw(6'h04, 32'h0000_0001, r);
    ws <= 4'hF;
    axr(6'h04, d, r);
    chk(d, 32'h0000_0004);
    chk(p_oe, 6'h04);
  endtask : t_output
  task automatic t_alt();
    logic [1:0] r;
    xen <= 6'h29; aoe <= 6'h10; aout <= 6'h00;
    axw(6'h10, 32'h0000_000B, r);
    settle();
    chk({p_oe[4], p_o[4]}, 2'b10);
    aout <= 6'h10;
    settle();
    chk(pin_lv[4], 1'b1);
    aoe <= 6'h00;
    settle();
    chk(p_oe, 6'h04);
  endtask : t_alt
  // Reset in mid-run with pads configured; every pad must fall back to input
  task automatic t_rerst();
    logic [31:0] d;
    logic [1:0] r;
    axw(6'h00, 32'h0000_0001, r);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    xen <= 6'h3F;
    xval <= 6'h12;
    @(posedge clk);
    #1;
    chk(p_oe, 6'h00);
    axr(gsl_pkg::PAD_IN_OFF, d, r);
    chk(d, 32'h0000_0012);
  endtask : t_rerst
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axw(6'h20, 32'h0000_0001, r);
    chk(r, gsl_pkg::RESP_SLVERR);
    axr(6'h24, d, r);
    chk(r, gsl_pkg::RESP_SLVERR);
    chk(d, 32'h0000_0000);
  endtask : t_unmapped
  // Lit cycles in one full period must equal the on-count of each mode
  task automatic t_lamp();
    int per[4] = '{40, 20, 40, 10};
    int on[4] = '{0, 10, 4, 5};
    int cnt;
    logic [1:0] r;
    for (int k = 1; k < 5; k++) begin
      axw(gsl_pkg::LAMP_MODE_OFF, 32'(k % 4), r);
      repeat (6) @(posedge clk);
      cnt = 0;
      repeat (per[k % 4]) begin @(posedge clk); #1; cnt += lit; end
      chk(cnt, on[k % 4]);
    end
    chk(pin, 1'b1);
  endtask : t_lamp
  initial begin
    miscompares = 0; n_compared = 0;
    rst = 1'b1; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; awa = 0; ara = 0; wd = 0;
    aoe = 0; aout = 0; xen = 0; xval = 0;
    ws = 4'hF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_input();
    t_output();
    t_alt();
    t_rerst();
    t_unmapped();
    t_lamp();
    results();
  end
endmodule : gsl_top_tb
